// ---- walk_ctrl_map.svh ----
`ifndef WALK_CTRL_MAP_SVH
`define WALK_CTRL_MAP_SVH
// register offsets on the plain register port (64-bit words split into halves)
`define OFF_HYP_CTRL_LO   4'h0
`define OFF_HYP_CTRL_HI   4'h1
`define OFF_MON_CTRL      4'h2
`define OFF_KLTB_LO       4'h3
`define OFF_KLTB_HI       4'h4
`define OFF_HLTB_LO       4'h5
`define OFF_HLTB_HI       4'h6
`define OFF_CONFIG        4'h7
// field positions
`define HPD_BIT           24
`define HD_BIT_HYP        22
`define HA_BIT_HYP        21
`define HD_BIT_HOST       40
`define HA_BIT_HOST       39
`define PS_LSB            16
`define TG_LSB            14
`define SH_LSB            12
`define ADDRESS_SPACE_ID_LSB          48
`define BASE_LSB          2
`define HBASE_LSB         1
`define DESC_APT0_BIT     61
`define DESC_PXNT_BIT     59
// config register bits
`define CFG_E2H_BIT       0
`define CFG_HYP_IMPL_BIT  1
// reset value chosen for the architecturally unknown fields
`define RST_VAL64         64'h0000_0000_0000_0000
`endif

// ---- walk_ctrl_pkg.sv ----
package walk_ctrl_pkg;
   typedef enum logic [1:0] {GRAN_4K, GRAN_64K, GRAN_16K, GRAN_RSVD} granule_t;
   typedef enum logic [1:0] {SH_NON, SH_RSVD, SH_OUTER, SH_INNER} share_t;
   typedef logic [63:0] word64_t;
endpackage

// ---- stage1_translation_control_regs.sv ----
`timescale 1ns/1ps
`include "walk_ctrl_map.svh"
module stage1_translation_control_regs #(
   parameter bit HD_IMPL = 1'b1,
   parameter bit HA_IMPL = 1'b1
) (
   input  wire logic                    ref_clk_in,
   input  wire logic                    rst_in,
   input  wire logic [3:0]              addr_in,
   input  wire logic [31:0]             wdata_in,
   input  wire logic                    wr_in,
   input  wire logic                    rd_in,
   output logic      [31:0]             rdata_out,
   input  wire logic                    address_space_id_source_select_in,
   input  wire logic [15:0]             kernel_high_address_space_id_in,
   input  wire logic                    monitor_walk_in,
   input  wire logic [63:0]             next_desc_in,
   output logic [63:0]                  walk_desc_out,
   output logic [63:0]                  walk_base_out,
   output logic [15:0]                  walk_address_space_id_out,
   output logic                         walk_shared_tlb_out,
   output logic                         walk_hpd_out,
   output logic                         walk_af_update_out,
   output logic                         walk_dirty_update_out,
   output logic [2:0]                   walk_phys_addr_size_out,
   output walk_ctrl_pkg::granule_t      walk_granule_out,
   output walk_ctrl_pkg::share_t        walk_shareability_out,
   output logic                         walk_cfg_reserved_out
);
   import walk_ctrl_pkg::*;

   word64_t     hyp_walk_control_ff;
   logic [31:0] monitor_walk_control_ff;
   word64_t     kernel_low_table_base_ff;
   word64_t     hyp_low_table_base_ff;
   logic        host_sel_ff;
   logic        hyp_impl_ff;
   logic [31:0] nxt_rdata;
   logic [63:0] hyp_mask;
   logic [63:0] hyp_view;
   logic [63:0] hbase_mask;
   logic [63:0] mon_mask;
   logic        hyp_acc;

   // optional update bits are masked out per layout when HD_IMPL/HA_IMPL is clear, so they read zero
   function automatic logic [63:0] hyp_ctrl_mask(input logic host);
      logic [63:0] m;
      m = '1;
      if (host) begin
         m[`HD_BIT_HOST] = HD_IMPL;
         m[`HA_BIT_HOST] = HA_IMPL;
      end else begin
         m[`HD_BIT_HYP] = HD_IMPL;
         m[`HA_BIT_HYP] = HA_IMPL;
      end
      return m;
   endfunction

   assign hyp_mask   = hyp_ctrl_mask(host_sel_ff);
   // monitor layout shares the hyp-layout optional bit positions
   assign mon_mask   = hyp_ctrl_mask(1'b0);
   // host mode opens the address_space_id field; otherwise upper bits stay zero
   assign hbase_mask = host_sel_ff ? 64'hFFFF_FFFF_FFFF_FFFD : 64'h0000_FFFF_FFFF_FFFF;
   assign hyp_acc    = hyp_impl_ff;
   assign hyp_view   = hyp_acc ? (hyp_walk_control_ff & hyp_mask) : 64'h0;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         host_sel_ff <= 1'b0;
         hyp_impl_ff <= 1'b1;
      end else if (wr_in && addr_in == `OFF_CONFIG) begin
         host_sel_ff <= wdata_in[`CFG_E2H_BIT];
         hyp_impl_ff <= wdata_in[`CFG_HYP_IMPL_BIT];
      end
   end

   // unknown reset modelled as zero; software must program first
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         hyp_walk_control_ff <= `RST_VAL64;
      end else if (wr_in && hyp_acc) begin
         if (addr_in == `OFF_HYP_CTRL_LO) begin
            hyp_walk_control_ff[31:0] <= wdata_in & hyp_mask[31:0];
         end else if (addr_in == `OFF_HYP_CTRL_HI) begin
            hyp_walk_control_ff[63:32] <= wdata_in & hyp_mask[63:32];
         end
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         monitor_walk_control_ff <= 32'h0000_0000;
      end else if (wr_in && addr_in == `OFF_MON_CTRL) begin
         monitor_walk_control_ff <= wdata_in & mon_mask[31:0];
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         kernel_low_table_base_ff <= `RST_VAL64;
      end else if (wr_in && addr_in == `OFF_KLTB_LO) begin
         kernel_low_table_base_ff[31:0] <= {wdata_in[31:2], 1'b0, wdata_in[0]};
      end else if (wr_in && addr_in == `OFF_KLTB_HI) begin
         kernel_low_table_base_ff[63:32] <= wdata_in;
      end
   end

   // misaligned low bits are stored as written and read back unchanged, except bit 1, which host mode clears
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         hyp_low_table_base_ff <= `RST_VAL64;
      end else if (wr_in && hyp_acc && addr_in == `OFF_HLTB_LO) begin
         hyp_low_table_base_ff[31:0] <= wdata_in & hbase_mask[31:0];
      end else if (wr_in && hyp_acc && addr_in == `OFF_HLTB_HI) begin
         hyp_low_table_base_ff[63:32] <= wdata_in & hbase_mask[63:32];
      end
   end

   always_comb begin
      unique case (addr_in)
         `OFF_HYP_CTRL_LO: nxt_rdata = hyp_view[31:0];
         `OFF_HYP_CTRL_HI: nxt_rdata = hyp_view[63:32];
         `OFF_MON_CTRL:    nxt_rdata = monitor_walk_control_ff;
         `OFF_KLTB_LO:     nxt_rdata = kernel_low_table_base_ff[31:0];
         `OFF_KLTB_HI:     nxt_rdata = kernel_low_table_base_ff[63:32];
         `OFF_HLTB_LO:     nxt_rdata = hyp_acc ? (hyp_low_table_base_ff[31:0] & hbase_mask[31:0]) : 32'h0;
         `OFF_HLTB_HI:     nxt_rdata = hyp_acc ? (hyp_low_table_base_ff[63:32] & hbase_mask[63:32]) : 32'h0;
         `OFF_CONFIG:      nxt_rdata = {30'h0, hyp_impl_ff, host_sel_ff};
         default:          nxt_rdata = 32'h0;
      endcase
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_out <= 32'h0000_0000;
      end else begin
         rdata_out <= rd_in ? nxt_rdata : 32'h0000_0000;
      end
   end

   // walk-side view; registered since tlb may cache any of it anyway
   logic [63:0] ctl;
   logic [63:0] base;
   logic        hd_bit;
   logic        ha_bit;
   always_comb begin
      ctl    = monitor_walk_in ? {32'h0, monitor_walk_control_ff} : hyp_view;
      base   = host_sel_ff ? (hyp_low_table_base_ff & hbase_mask) : kernel_low_table_base_ff;
      if (host_sel_ff && !monitor_walk_in) begin
         hd_bit = ctl[`HD_BIT_HOST];
         ha_bit = ctl[`HA_BIT_HOST];
      end else begin
         hd_bit = ctl[`HD_BIT_HYP];
         ha_bit = ctl[`HA_BIT_HYP];
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         walk_base_out           <= 64'h0;
         walk_address_space_id_out           <= 16'h0;
         walk_shared_tlb_out     <= 1'b0;
         walk_hpd_out            <= 1'b0;
         walk_af_update_out      <= 1'b0;
         walk_dirty_update_out   <= 1'b0;
         walk_phys_addr_size_out <= 3'h0;
         walk_granule_out        <= GRAN_4K;
         walk_shareability_out   <= SH_NON;
         walk_cfg_reserved_out   <= 1'b0;
         walk_desc_out           <= 64'h0;
      end else begin
         walk_base_out         <= {16'h0, base[47:`HBASE_LSB], 1'b0};
         walk_address_space_id_out         <= address_space_id_source_select_in ? kernel_high_address_space_id_in : base[63:`ADDRESS_SPACE_ID_LSB];
         walk_shared_tlb_out   <= base[0];
         walk_hpd_out          <= (host_sel_ff && !monitor_walk_in) ? 1'b0 : ctl[`HPD_BIT];
         walk_af_update_out    <= ha_bit;
         walk_dirty_update_out <= hd_bit & ha_bit;
         walk_phys_addr_size_out <= ctl[`PS_LSB+:3];
         walk_granule_out      <= granule_t'(ctl[`TG_LSB+:2]);
         walk_shareability_out <= share_t'(ctl[`SH_LSB+:2]);
         walk_cfg_reserved_out <= (ctl[`PS_LSB+:3] > 3'h2) || (ctl[`TG_LSB+:2] == 2'h3)
                                  || (ctl[`SH_LSB+:2] == 2'h1);
         walk_desc_out         <= next_desc_in;
         // hierarchical bits ignored: table access, priv and user xn cleared, nonsecure kept
         if ((host_sel_ff && !monitor_walk_in) ? 1'b0 : ctl[`HPD_BIT]) begin
            walk_desc_out[`DESC_APT0_BIT+1] <= 1'b0;
            walk_desc_out[`DESC_APT0_BIT]   <= 1'b0;
            walk_desc_out[`DESC_APT0_BIT-1] <= 1'b0;
            walk_desc_out[`DESC_PXNT_BIT]   <= 1'b0;
         end
      end
   end

   hyp_read_zero_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (rd_in && !hyp_impl_ff && addr_in == `OFF_HYP_CTRL_LO) |=> rdata_out == 32'h0)
      else $error("hyp control not zero when level absent");
   dirty_needs_af_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      walk_dirty_update_out |-> walk_af_update_out)
      else $error("dirty update without access flag");
   // write, one idle cycle, then read: the pattern software uses
   sequence wr_mon_s;
      wr_in && addr_in == `OFF_MON_CTRL;
   endsequence
   sequence rd_mon_s;
      rd_in && addr_in == `OFF_MON_CTRL && !wr_in;
   endsequence
   sequence wr_hbase_lo_s;
      wr_in && hyp_impl_ff && !host_sel_ff && addr_in == `OFF_HLTB_LO;
   endsequence
   sequence rd_hbase_lo_s;
      rd_in && hyp_impl_ff && addr_in == `OFF_HLTB_LO && $stable(host_sel_ff);
   endsequence

   mon_readback_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      wr_mon_s ##1 !wr_in ##1 rd_mon_s |=> rdata_out == ($past(wdata_in, 3) & mon_mask[31:0]))
      else $error("monitor control readback wrong");
   hbase_echo_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      wr_hbase_lo_s ##1 !wr_in ##1 rd_hbase_lo_s |=> rdata_out == $past(wdata_in, 3))
      else $error("hyp base low readback altered");
   hbase_upper_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (rd_in && !host_sel_ff && addr_in == `OFF_HLTB_HI) |=> rdata_out[31:16] == 16'h0)
      else $error("hyp base reserved bits nonzero");
   kbase_bit1_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (rd_in && addr_in == `OFF_KLTB_LO) |=> rdata_out[1] == 1'b0)
      else $error("kernel base reserved bit set");
   desc_ignore_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      walk_hpd_out |-> !walk_desc_out[`DESC_PXNT_BIT] && !walk_desc_out[`DESC_APT0_BIT])
      else $error("descriptor bit 59 or 61 passed while hpd set");
   desc_pass_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !$past(rst_in) && !walk_hpd_out |-> walk_desc_out == $past(next_desc_in))
      else $error("descriptor altered while hpd clear");
   ns_kept_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !$past(rst_in) |-> walk_desc_out[63] == $past(next_desc_in[63]))
      else $error("nonsecure table bit not kept");
   hpd_host_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $past(host_sel_ff && !monitor_walk_in) |-> !walk_hpd_out)
      else $error("hpd applied in host layout");
   af_hyp_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $past(!host_sel_ff && !monitor_walk_in) |-> walk_af_update_out == $past(hyp_view[`HA_BIT_HYP]))
      else $error("hyp access flag enable wrong");
   af_host_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $past(host_sel_ff && !monitor_walk_in) |-> walk_af_update_out == $past(hyp_view[`HA_BIT_HOST]))
      else $error("host access flag enable wrong");
   af_mon_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $past(monitor_walk_in) |-> walk_af_update_out == $past(monitor_walk_control_ff[`HA_BIT_HYP]))
      else $error("monitor access flag enable wrong");
   ps_follow_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $past(!monitor_walk_in) |-> walk_phys_addr_size_out == $past(hyp_view[`PS_LSB+:3]))
      else $error("phys addr size not passed to walk");
   ps_reserved_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      walk_phys_addr_size_out > 3'h2 |-> walk_cfg_reserved_out)
      else $error("reserved size code not flagged");
   gran_reserved_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      walk_granule_out == GRAN_RSVD |-> walk_cfg_reserved_out)
      else $error("reserved granule not flagged");
   share_reserved_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      walk_shareability_out == SH_RSVD |-> walk_cfg_reserved_out)
      else $error("reserved shareability not flagged");
   base_kernel_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $past(!host_sel_ff) |-> walk_base_out == {16'h0, $past(kernel_low_table_base_ff[47:1]), 1'b0})
      else $error("kernel base not used");
   base_hyp_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $past(host_sel_ff) |-> walk_base_out == {16'h0, $past(hyp_low_table_base_ff[47:2]), 2'h0})
      else $error("hyp base not used in host mode");
   address_space_id_high_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !$past(rst_in) && $past(address_space_id_source_select_in) |-> walk_address_space_id_out == $past(kernel_high_address_space_id_in))
      else $error("high address_space_id not selected");
   cnp_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      walk_shared_tlb_out == $past(host_sel_ff ? hyp_low_table_base_ff[0] : kernel_low_table_base_ff[0]))
      else $error("shared tlb bit wrong");
   hyp_wr_block_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !hyp_impl_ff && wr_in && (addr_in == `OFF_HYP_CTRL_LO || addr_in == `OFF_HYP_CTRL_HI)
      |=> $stable(hyp_walk_control_ff))
      else $error("hyp control written while level absent");
   hbase_wr_block_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !hyp_impl_ff && wr_in && (addr_in == `OFF_HLTB_LO || addr_in == `OFF_HLTB_HI)
      |=> $stable(hyp_low_table_base_ff))
      else $error("hyp base written while level absent");
   kbase_store_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      wr_in && addr_in == `OFF_KLTB_LO
      |=> kernel_low_table_base_ff[31:0] == {$past(wdata_in[31:2]), 1'b0, $past(wdata_in[0])})
      else $error("kernel base low word stored wrong");
   opt_bits_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !HA_IMPL |-> !walk_af_update_out)
      else $error("absent access flag bit reads set");
   unmapped_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (rd_in && addr_in > `OFF_CONFIG) |=> rdata_out == 32'h0)
      else $error("unmapped read not zero");
endmodule

// ---- stage1_translation_control_regs_test.sv ----
`timescale 1ns/1ps
`include "walk_ctrl_map.svh"
module stage1_translation_control_regs_test;
   import walk_ctrl_pkg::*;
   logic          ref_clk_in, rst_in, wr_in, rd_in, address_space_id_source_select_in, monitor_walk_in;
   logic          walk_shared_tlb_out, walk_hpd_out, walk_af_update_out, walk_dirty_update_out;
   logic          walk_cfg_reserved_out;
   logic [3:0]    addr_in;
   logic [31:0]   wdata_in, rdata_out;
   logic [15:0]   kernel_high_address_space_id_in, walk_address_space_id_out;
   logic [63:0]   next_desc_in, walk_desc_out, walk_base_out;
   logic [2:0]    walk_phys_addr_size_out;
   granule_t      walk_granule_out;
   share_t        walk_shareability_out;
   int            num_errors, tests_run;

   stage1_translation_control_regs uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .address_space_id_source_select_in(address_space_id_source_select_in), .kernel_high_address_space_id_in(kernel_high_address_space_id_in),
      .monitor_walk_in(monitor_walk_in), .next_desc_in(next_desc_in), .walk_desc_out(walk_desc_out),
      .walk_base_out(walk_base_out), .walk_address_space_id_out(walk_address_space_id_out),
      .walk_shared_tlb_out(walk_shared_tlb_out), .walk_hpd_out(walk_hpd_out),
      .walk_af_update_out(walk_af_update_out), .walk_dirty_update_out(walk_dirty_update_out),
      .walk_phys_addr_size_out(walk_phys_addr_size_out), .walk_granule_out(walk_granule_out),
      .walk_shareability_out(walk_shareability_out), .walk_cfg_reserved_out(walk_cfg_reserved_out));

   initial begin
      ref_clk_in = 1'b0;
      forever #10 ref_clk_in = ~ref_clk_in;
   end

   task automatic chk_read(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_walk(input string what, input logic [63:0] exp, input logic [63:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge ref_clk_in);
      wr_in <= 1'b0;
      @(posedge ref_clk_in);
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge ref_clk_in);
      rd_in <= 1'b0;
      #1;
      chk_read(what, exp, rdata_out);
      @(posedge ref_clk_in);
   endtask

   // walk outputs lag the register by one more cycle
   task automatic walk_chk(input logic hier_perm_disable, af, dirty, input logic [2:0] ps, input logic [1:0] gr, sh,
                           input logic rsv);
      repeat (2) @(posedge ref_clk_in);
      #1;
      chk_walk("walk fields", {53'h0, hier_perm_disable, af, dirty, ps, gr, sh, rsv}, {53'h0, walk_hpd_out,
         walk_af_update_out, walk_dirty_update_out, walk_phys_addr_size_out, walk_granule_out,
         walk_shareability_out, walk_cfg_reserved_out});
      chk_walk("walk desc", hier_perm_disable ? (next_desc_in & 64'h87FF_FFFF_FFFF_FFFF) : next_desc_in, walk_desc_out);
   endtask

   task automatic base_chk(input logic [63:0] base, input logic [15:0] address_space_id, input logic shr);
      repeat (2) @(posedge ref_clk_in);
      #1;
      chk_walk("walk base", base, walk_base_out);
      chk_walk("walk address_space_id", {48'h0, address_space_id}, {48'h0, walk_address_space_id_out});
      chk_walk("shared tlb", {63'h0, shr}, {63'h0, walk_shared_tlb_out});
   endtask

   task automatic t_reset();
      for (int a = 0; a < 16; a++)
         rd_chk(a[3:0], (a == 7) ? 32'h0000_0002 : 32'h0000_0000, "reset value");
      $display("test reset done");
   endtask

   task automatic t_hyp_fields();
      wr_reg(`OFF_HYP_CTRL_LO, 32'h0162_6000);
      rd_chk(`OFF_HYP_CTRL_LO, 32'h0162_6000, "hyp ctrl");
      walk_chk(1'b1, 1'b1, 1'b1, 3'h2, 2'h1, 2'h2, 1'b0);
      wr_reg(`OFF_HYP_CTRL_LO, 32'h0040_0000);
      walk_chk(1'b0, 1'b0, 1'b0, 3'h0, 2'h0, 2'h0, 1'b0);
      wr_reg(`OFF_HYP_CTRL_LO, 32'h0003_0000);
      walk_chk(1'b0, 1'b0, 1'b0, 3'h3, 2'h0, 2'h0, 1'b1);
      wr_reg(`OFF_HYP_CTRL_LO, 32'h0000_C000);
      walk_chk(1'b0, 1'b0, 1'b0, 3'h0, 2'h3, 2'h0, 1'b1);
      wr_reg(`OFF_HYP_CTRL_LO, 32'h0000_1000);
      walk_chk(1'b0, 1'b0, 1'b0, 3'h0, 2'h0, 2'h1, 1'b1);
      $display("test hyp fields done");
   endtask

   task automatic t_host();
      wr_reg(`OFF_CONFIG, 32'h0000_0003);
      wr_reg(`OFF_HYP_CTRL_HI, 32'h0000_0180);
      wr_reg(`OFF_HYP_CTRL_LO, 32'h0100_B000);
      walk_chk(1'b0, 1'b1, 1'b1, 3'h0, 2'h2, 2'h3, 1'b0);
      wr_reg(`OFF_HLTB_LO, 32'h1234_5679);
      wr_reg(`OFF_HLTB_HI, 32'hABCD_0012);
      rd_chk(`OFF_HLTB_HI, 32'hABCD_0012, "host hyp base hi");
      base_chk(64'h0000_0012_1234_5678, 16'hABCD, 1'b1);
      address_space_id_source_select_in <= 1'b1;
      base_chk(64'h0000_0012_1234_5678, 16'h1357, 1'b1);
      address_space_id_source_select_in <= 1'b0;
      $display("test host layout done");
   endtask

   task automatic t_kernel();
      wr_reg(`OFF_CONFIG, 32'h0000_0002);
      wr_reg(`OFF_KLTB_LO, 32'h8765_4321);
      wr_reg(`OFF_KLTB_HI, 32'h5A5A_00FF);
      rd_chk(`OFF_KLTB_HI, 32'h5A5A_00FF, "kernel base hi");
      base_chk(64'h0000_00FF_8765_4320, 16'h5A5A, 1'b1);
      wr_reg(`OFF_HLTB_HI, 32'hFFFF_0001);
      rd_chk(`OFF_HLTB_HI, 32'h0000_0001, "hyp base hi");
      wr_reg(`OFF_HLTB_LO, 32'h0000_0FFE);
      rd_chk(`OFF_HLTB_LO, 32'h0000_0FFE, "hyp base lo");
      $display("test kernel base done");
   endtask

   task automatic t_monitor();
      monitor_walk_in <= 1'b1;
      wr_reg(`OFF_MON_CTRL, 32'h0021_3000);
      rd_chk(`OFF_MON_CTRL, 32'h0021_3000, "monitor ctrl");
      walk_chk(1'b0, 1'b1, 1'b0, 3'h1, 2'h0, 2'h3, 1'b0);
      wr_reg(`OFF_MON_CTRL, 32'h0140_0000);
      walk_chk(1'b1, 1'b0, 1'b0, 3'h0, 2'h0, 2'h0, 1'b0);
      monitor_walk_in <= 1'b0;
      $display("test monitor done");
   endtask

   task automatic t_no_hyp();
      wr_reg(`OFF_HYP_CTRL_LO, 32'h0000_6000);
      wr_reg(`OFF_CONFIG, 32'h0000_0000);
      wr_reg(`OFF_HYP_CTRL_LO, 32'h0162_6000);
      rd_chk(`OFF_HYP_CTRL_LO, 32'h0000_0000, "absent hyp ctrl");
      rd_chk(`OFF_HLTB_HI, 32'h0000_0000, "absent hyp base");
      wr_reg(`OFF_CONFIG, 32'h0000_0002);
      rd_chk(`OFF_HYP_CTRL_LO, 32'h0000_6000, "write ignored");
      $display("test absent hyp level done");
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // about 120 cycles of traffic; generous margin
   initial begin
      #200000;
      num_errors++;
      end_of_test();
   end

   initial begin
      rst_in = 1'b1;
      {wr_in, rd_in, address_space_id_source_select_in, monitor_walk_in} = 4'h0;
      addr_in = 4'h0;
      wdata_in = 32'h0;
      kernel_high_address_space_id_in = 16'h1357;
      next_desc_in = 64'hFFFF_FFFF_FFFF_FFFF;
      repeat (4) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      @(posedge ref_clk_in);
      t_reset();
      t_hyp_fields();
      t_host();
      t_kernel();
      t_monitor();
      t_no_hyp();
      end_of_test();
   end
endmodule
